// ==== logic/dsw_serial_port.sv ====
// Serial write port: frame receiver, word buffer and converter/mode registers
//
// Summary of operation
// - Shift data in on falling clock edges
// - Frame starts when frame-sync goes low
// - Apply word after the 24th clock
// - Early frame-sync rise aborts the frame
// - Converter code is 16-bit unsigned
// - Two mode bits choose output stage
// - Sixteen data bits follow the mode bits
// - Reset loads zero or midscale code
`include "dsw_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_port
  import dsw_pkg::*;
#(
  parameter bit RESET_MIDSCALE = 1'b0,
  parameter int WORD_BITS = `DSW_WORD_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial pins from the host
  input wire logic sclk,
  input wire logic syncN,
  input wire logic din,
  // Apply side
  input wire logic applyReady,
  output logic [15:0] dacCode,
  output dsw_pmode_t powerMode,
  output logic codeUpdate,
  output logic overrun
);
  // --------------------------------
  // Pin synchronisers
  // --------------------------------
  logic sclkMeta_q;  // First stage, read only by the second
  logic sclkSync_q;
  logic sclkPrev_q;  // For edge detection
  logic syncMeta_q;
  logic syncSync_q;
  logic syncPrev_q;
  logic dinMeta_q;
  logic dinSync_q;

  // Two flops per pin; the pins idle high for clock and frame-sync
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sclkMeta_q <= 1'b1;
      sclkSync_q <= 1'b1;
      sclkPrev_q <= 1'b1;
      syncMeta_q <= 1'b1;
      syncSync_q <= 1'b1;
      syncPrev_q <= 1'b1;
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end
    else
    begin
      sclkMeta_q <= sclk;
      sclkSync_q <= sclkMeta_q;
      sclkPrev_q <= sclkSync_q;
      syncMeta_q <= syncN;
      syncSync_q <= syncMeta_q;
      syncPrev_q <= syncSync_q;
      dinMeta_q <= din;
      dinSync_q <= dinMeta_q;
    end
  end

  // Edges seen after synchronisation; data is delayed alike so it lines up
  // with the clock edge. The 30 MHz host limit leaves about three samples
  // per serial period, so short clock phases rely on the host's margins.
  logic sclkFall;
  logic syncFall;
  logic syncRise;
  assign sclkFall = sclkPrev_q & ~sclkSync_q;
  assign syncFall = syncPrev_q & ~syncSync_q;
  assign syncRise = ~syncPrev_q & syncSync_q;

  // --------------------------------
  // Frame receiver
  // --------------------------------
  dsw_state_t state_q;
  dsw_state_t state_d;
  logic [WORD_BITS-1:0] shift_q;  // Input shift register
  logic [4:0] bitCnt_q;  // Bits taken in this frame
  logic lastBit;

  assign lastBit = (bitCnt_q == `DSW_LAST_BIT);

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        // Only a falling frame-sync opens a frame
        if (syncFall)
        begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (syncRise)
        begin
          state_d = ST_IDLE;
        end
        else if (sclkFall && lastBit)
        begin
          state_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Extra clocks are ignored until frame-sync goes high again
        if (syncRise)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Shift register and bit count; a partial frame is cleared on abort
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shift_q <= '0;
      bitCnt_q <= '0;
    end
    else if (state_q != ST_SHIFT || syncRise)
    begin
      bitCnt_q <= '0;
      if (state_q == ST_IDLE || syncRise)
      begin
        shift_q <= '0;
      end
    end
    else if (sclkFall)
    begin
      // First bit ends in the top position
      shift_q <= {shift_q[WORD_BITS-2:0], dinSync_q};
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // --------------------------------
  // Completed word into the buffer
  // --------------------------------
  dsw_word_if #(.W(`DSW_PAYLOAD_BITS)) pushIf ();
  dsw_word_if #(.W(`DSW_PAYLOAD_BITS)) popIf ();
  logic push_q;  // One-cycle push of a finished word
  logic [`DSW_PAYLOAD_BITS-1:0] pushData_q;
  logic complete;

  assign complete = (state_q == ST_SHIFT) && !syncRise && sclkFall && lastBit;

  // Capture mode bits and data, including the bit arriving now
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      push_q <= 1'b0;
      pushData_q <= '0;
    end
    else
    begin
      push_q <= complete;
      if (complete)
      begin
        pushData_q <= {shift_q[`DSW_PAYLOAD_BITS-2:0], dinSync_q};
      end
    end
  end

  assign pushIf.valid = push_q;
  assign pushIf.data = pushData_q;

  dsw_word_buf #(
    .W(`DSW_PAYLOAD_BITS),
    .DEPTH(`DSW_BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .rst(rst),
    .wr(pushIf),
    .rd(popIf)
  );

  // The host cannot be stalled; a word meeting a full buffer is dropped
  // and flagged, sticky until reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      overrun <= 1'b0;
    end
    else if (push_q && !pushIf.ready)
    begin
      overrun <= 1'b1;
    end
  end

  // --------------------------------
  // Converter and mode registers
  // --------------------------------
  logic apply;
  assign popIf.ready = applyReady;
  assign apply = popIf.valid & applyReady;

  // Reset code holds until the first complete frame is applied
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dacCode <= RESET_MIDSCALE ? `DSW_CODE_MID : `DSW_CODE_ZERO;
      powerMode <= PM_NORMAL;
      codeUpdate <= 1'b0;
    end
    else
    begin
      codeUpdate <= apply;
      if (apply)
      begin
        // Full 16-bit unsigned code, 0000 zero scale to FFFF full scale
        dacCode <= popIf.data[`DSW_CODE_HI:`DSW_CODE_LO];
        powerMode <= dsw_pmode_t'(popIf.data[`DSW_MODE_HI:`DSW_MODE_LO]);
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/dsw_defs.svh ====
// Constants of the serial write port: word layout, reset values, timing
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH
`define DSW_WORD_BITS 24
`define DSW_PAYLOAD_BITS 18
`define DSW_MODE_HI 17
`define DSW_MODE_LO 16
`define DSW_CODE_HI 15
`define DSW_CODE_LO 0
`define DSW_LAST_BIT 5'h17
`define DSW_CODE_ZERO 16'h0000
`define DSW_CODE_MID 16'h8000
`define DSW_CODE_FULL 16'hFFFF
`define DSW_MODE_RESET 2'h0
`define DSW_BUF_DEPTH 2
`define DSW_MCLK_MHZ 100
`define DSW_SCLK_MAX_MHZ 30
`define DSW_SYNC_HIGH_NS 33
`define DSW_SYNC_HIGH_CYC ((`DSW_SYNC_HIGH_NS * `DSW_MCLK_MHZ + 999) / 1000)
`endif

// ==== logic/dsw_pkg.sv ====
// Types shared by the serial write port modules
package dsw_pkg;
  // Output stage modes carried in the two mode bits
  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_FLOAT = 2'h1,
    PM_R100K = 2'h2,
    PM_R1K = 2'h3
  } dsw_pmode_t;
  // Frame receiver states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_DONE = 3'h4
  } dsw_state_t;
endpackage

// ==== logic/dsw_word_if.sv ====
// Valid/ready word carrier between the receiver and its buffer
`timescale 1ns/1ps
`default_nettype none
interface dsw_word_if #(parameter int W = 18);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ==== logic/dsw_word_buf.sv ====
// Two-entry valid/ready buffer for completed words
`timescale 1ns/1ps
`default_nettype none
module dsw_word_buf #(
  parameter int W = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Filling side
  dsw_word_if.snk wr,
  // Draining side
  dsw_word_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];  // Storage cells
  logic [AW-1:0] wrPtr_q;  // Next cell to fill
  logic [AW-1:0] rdPtr_q;  // Oldest cell
  logic [AW:0] count_q;  // Words held
  logic doWr;
  logic doRd;

  // --------------------------------
  // Handshakes
  // --------------------------------
  // Full and empty come straight from the count, so they never lie
  // The count is one bit wider than a pointer so that a full buffer is told apart
  assign wr.ready = (count_q != (AW+1)'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data = mem_q[rdPtr_q];
  assign doWr = wr.valid & wr.ready;
  assign doRd = rd.valid & rd.ready;

  // Storage write
  always_ff @(posedge mclk)
  begin
    if (doWr)
    begin
      mem_q[wrPtr_q] <= wr.data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRd)
      begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      count_q <= '0;
    end
    else if (doWr && !doRd)
    begin
      count_q <= count_q + 1'b1;
    end
    else if (doRd && !doWr)
    begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/dsw_host_model.sv ====
// Host side model driving the three serial pins
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic sclk,
  output logic syncN,
  output logic din
);
  // Pins idle: clock parked high, no frame
  initial
  begin
    sclk = 1'b1;
    syncN = 1'b1;
    din = 1'b0;
  end
  // Wait n edges, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Send n bits, three mclk per phase (about 16.7 MHz)
  task automatic send(input logic [23:0] w, input int n);
    syncN = 1'b0;
    step(3);
    for (int i = 0; i < n; i++)
    begin
      din = w[(47 - i) % 24];
      step(3);
      sclk = 1'b0;
      step(3);
      sclk = 1'b1;
    end
    step(3);
    syncN = 1'b1;
    // Released line shows no stale bit
    din = ~din;
    step(6);
  endtask
endmodule
`default_nettype wire

// ==== sim/dsw_serial_port_properties.sv ====
// Output checker for the serial write port
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_port_chk
  import dsw_pkg::*;
#(
  parameter bit RESET_MIDSCALE = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins and apply side
  input wire logic syncN,
  input wire logic applyReady,
  input wire logic [15:0] dacCode,
  input wire dsw_pmode_t powerMode,
  input wire logic codeUpdate,
  input wire logic overrun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----
  // Sequences
  // ----
  // Drain held off
  sequence stall;
    !applyReady [*3];
  endsequence
  // No frame and drain open, so the buffer empties
  sequence idle;
    (syncN && applyReady) [*8];
  endsequence
  // ----
  // Properties
  // ----
  chk_reset_value: assert property (
    $fell(rst) |-> dacCode == (RESET_MIDSCALE ? 16'h8000 : 16'h0000)
    && powerMode == PM_NORMAL && !codeUpdate && !overrun)
    else $error("reset values wrong");
  chk_code_cause: assert property ($changed(dacCode) |-> codeUpdate)
    else $error("code changed without pulse");
  chk_mode_cause: assert property ($changed(powerMode) |-> codeUpdate)
    else $error("mode changed without pulse");
  chk_update_ready: assert property (codeUpdate |-> $past(applyReady))
    else $error("pulse without drain");
  chk_change_ready: assert property ($changed(dacCode) |-> $past(applyReady))
    else $error("code changed without drain");
  chk_stall_quiet: assert property (stall |-> !codeUpdate)
    else $error("update while stalled");
  chk_idle_quiet: assert property (idle |=> !codeUpdate)
    else $error("update with no frame");
  // Lost words must stay visible until reset
  chk_overrun_sticky: assert property (overrun |=> overrun)
    else $error("overrun cleared");
endmodule
bind dsw_serial_port dsw_serial_port_chk #(.RESET_MIDSCALE(RESET_MIDSCALE)) chk (
  .mclk(mclk), .rst(rst), .syncN(syncN), .applyReady(applyReady), .dacCode(dacCode),
  .powerMode(powerMode), .codeUpdate(codeUpdate), .overrun(overrun));
`default_nettype wire

// ==== sim/dac_serial_write_port_test.sv ====
// Self-checking bench for the serial write port
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_test;
  import dsw_pkg::*;
  logic mclk, rst, applyReady, sclk, syncN, din, codeUpdate, overrun;
  logic [15:0] dacCode;
  dsw_pmode_t powerMode;
  int bad_count = 0;
  int checks = 0;
  int updates = 0;
  int n;
  // Word sent, code and mode it must give
  typedef struct packed {logic [23:0] w; logic [15:0] c; logic [1:0] m;} dsw_row_t;
  dsw_row_t rows [6] = '{'{24'h00FFFF, 16'hFFFF, 2'h0}, '{24'h010000, 16'h0000, 2'h1},
    '{24'h02A5A5, 16'hA5A5, 2'h2}, '{24'h035A5A, 16'h5A5A, 2'h3},
    '{24'hFC8001, 16'h8001, 2'h0}, '{24'h000000, 16'h0000, 2'h0}};
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  dsw_host_model host (.mclk(mclk), .sclk(sclk), .syncN(syncN), .din(din));
  dsw_serial_port dut (.mclk(mclk), .rst(rst), .sclk(sclk), .syncN(syncN), .din(din),
    .applyReady(applyReady), .dacCode(dacCode), .powerMode(powerMode),
    .codeUpdate(codeUpdate), .overrun(overrun));
  // Count apply pulses
  // Sampled on the falling edge, clear of the edge that launches the pulse
  always @(negedge mclk) if (codeUpdate === 1'b1) updates++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Send a frame, then compare pulses, code and mode
  task automatic frame(input logic [23:0] w, input int b, input int u,
    input logic [15:0] c, input logic [1:0] m, input logic a);
    n = updates;
    // Drain level during the frame; a held word drains once the frame is over only when u is nonzero
    applyReady = a;
    host.send(w, b);
    applyReady = (u != 0);
    host.step(10);
    check(16'(updates - n), 16'(u));
    check(dacCode, c);
    check({14'h0000, powerMode}, {14'h0000, m});
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, about twice the expected run
  initial
  begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    applyReady = 1'b1;
    host.step(10);
    rst = 1'b0;
    check(dacCode, 16'h0000);
    host.step(4);
    // Ordinary words, every mode and both scale ends; even codes wait in the buffer
    for (int i = 0; i < 6; i++)
      frame(rows[i].w, 24, 1, rows[i].c, rows[i].m, rows[i].w[0]);
    // Early rise aborts, next full frame starts clean
    frame(24'h03ABCD, 23, 0, 16'h0000, 2'h0, 1'b1);
    frame(24'h001111, 24, 1, 16'h1111, 2'h0, 1'b1);
    // Falls after the 24th are ignored
    frame(24'h027777, 25, 1, 16'h7777, 2'h2, 1'b1);
    // Stalled drain: two words held, third dropped
    frame(24'h004444, 24, 0, 16'h7777, 2'h2, 1'b0);
    frame(24'h015555, 24, 0, 16'h7777, 2'h2, 1'b0);
    frame(24'h026666, 24, 0, 16'h7777, 2'h2, 1'b0);
    check({15'h0000, overrun}, 16'h0001);
    n = updates;
    applyReady = 1'b1;
    host.step(10);
    check(16'(updates - n), 16'h0002);
    check(dacCode, 16'h5555);
    check({14'h0000, powerMode}, 16'h0001);
    // Reset in mid-run restores the power-on state
    rst = 1'b1;
    host.step(10);
    rst = 1'b0;
    check({15'h0000, overrun}, 16'h0000);
    check(dacCode, 16'h0000);
    host.step(4);
    // The port works again after a reset in mid-run
    frame(24'h021234, 24, 1, 16'h1234, 2'h2, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
